// ### src/iopcd_top.sv
// Input levels and change-of-state detection for I/O ports A and B
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "iopcd_cfg.svh"
module iopcd_top
  import iopcd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire logic [`IOPCD_AW-1:0] reg_addr,
  input wire logic [`IOPCD_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`IOPCD_DW-1:0] reg_rdata,
  // Port A pins
  input wire logic [7:0] port_a_pin,
  // Port B pins
  input wire logic port_b_pin0,
  input wire logic port_b_pin2,
  input wire logic port_b_pin3,
  input wire logic port_b_pin4,
  input wire logic port_b_pin6,
  // Pin directions, one per pin
  input wire logic [7:0] port_a_dir_out,
  input wire logic [7:0] port_b_dir_out,
  // Interrupt
  output logic irq
);
  iopcd_byte_t lvl_a;
  iopcd_byte_t lvl_b;
  iopcd_byte_t en_a;
  iopcd_byte_t en_b;
  iopcd_byte_t shown_a;
  iopcd_byte_t shown_b;
  iopcd_byte_t next_clr_a;
  iopcd_byte_t next_clr_b;
  iopcd_byte_t next_rdata;
  iopcd_byte_t irq_evt;
  iopcd_byte_t irq_status;
  iopcd_byte_t irq_mask;
  iopcd_sel_e sel;
  logic wr_stat;
  logic wr_mask;

  // ****************************************
  // Pin sampling
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lvl_a <= 8'h00;
    end else begin
      lvl_a <= port_a_pin;
    end
  end

  // Unimplemented port B positions stay low
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lvl_b <= 8'h00;
    end else begin
      lvl_b <= {1'b0, port_b_pin6, 1'b0, port_b_pin4,
                port_b_pin3, port_b_pin2, 1'b0, port_b_pin0};
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  always_comb begin
    if (reg_addr == `IOPCD_A_UP_OFS) begin
      sel = IOPCD_SEL_A_UP;
    end else if (reg_addr == `IOPCD_A_LOW_OFS) begin
      sel = IOPCD_SEL_A_LOW;
    end else if (reg_addr == `IOPCD_A_IN_OFS) begin
      sel = IOPCD_SEL_A_IN;
    end else if (reg_addr == `IOPCD_B_UP_OFS) begin
      sel = IOPCD_SEL_B_UP;
    end else if (reg_addr == `IOPCD_B_LOW_OFS) begin
      sel = IOPCD_SEL_B_LOW;
    end else if (reg_addr == `IOPCD_B_IN_OFS) begin
      sel = IOPCD_SEL_B_IN;
    end else if (reg_addr == `IOPCD_A_EN_OFS) begin
      sel = IOPCD_SEL_A_EN;
    end else if (reg_addr == `IOPCD_B_EN_OFS) begin
      sel = IOPCD_SEL_B_EN;
    end else if (reg_addr == `IOPCD_IRQ_STAT_OFS) begin
      sel = IOPCD_SEL_STAT;
    end else if (reg_addr == `IOPCD_IRQ_MASK_OFS) begin
      sel = IOPCD_SEL_MASK;
    end else begin
      sel = IOPCD_SEL_NONE;
    end
  end

  // ****************************************
  // Enable registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      en_a <= `IOPCD_EN_RST;
    end else if (reg_wr && sel == IOPCD_SEL_A_EN) begin
      en_a <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      en_b <= `IOPCD_EN_RST;
    end else if (reg_wr && sel == IOPCD_SEL_B_EN) begin
      en_b <= reg_wdata & `IOPCD_B_IMPL;
    end
  end

  // ****************************************
  // Detector banks
  // ****************************************
  iopcd_cos_if #(.W(8)) cos_a ();
  iopcd_cos_if #(.W(8)) cos_b ();

  assign cos_a.lvl = lvl_a;
  assign cos_a.en = en_a;
  assign cos_a.clr = next_clr_a;
  assign cos_b.lvl = lvl_b;
  assign cos_b.en = en_b;
  assign cos_b.clr = next_clr_b;

  iopcd_cos_det #(.W(8)) u_det_a (
    .clk_sys(clk_sys),
    .srst(srst),
    .cos(cos_a.det)
  );

  iopcd_cos_det #(.W(8)) u_det_b (
    .clk_sys(clk_sys),
    .srst(srst),
    .cos(cos_b.det)
  );

  // Flags keep being set on outputs but are hidden on readout
  assign shown_a = cos_a.flag & en_a & ~port_a_dir_out;
  assign shown_b = cos_b.flag & en_b & ~port_b_dir_out & `IOPCD_B_IMPL;

  // ****************************************
  // Clear on read of the holding register
  // ****************************************
  always_comb begin
    next_clr_a = 8'h00;
    next_clr_b = 8'h00;
    if (reg_rd) begin
      if (sel == IOPCD_SEL_A_LOW) begin
        next_clr_a = `IOPCD_LOW_NIB;
      end else if (sel == IOPCD_SEL_A_UP) begin
        next_clr_a = `IOPCD_HIGH_NIB;
      end else if (sel == IOPCD_SEL_B_LOW) begin
        next_clr_b = `IOPCD_LOW_NIB & `IOPCD_B_IMPL;
      end else if (sel == IOPCD_SEL_B_UP) begin
        next_clr_b = `IOPCD_HIGH_NIB & `IOPCD_B_IMPL;
      end
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    next_rdata = 8'h00;
    case (sel)
      IOPCD_SEL_A_UP: begin
        next_rdata = {shown_a[7:4], lvl_a[7:4]};
      end
      IOPCD_SEL_A_LOW: begin
        next_rdata = {shown_a[3:0], lvl_a[3:0]};
      end
      IOPCD_SEL_A_IN: begin
        next_rdata = lvl_a;
      end
      IOPCD_SEL_B_UP: begin
        next_rdata = {1'b0, shown_b[6], 1'b0, shown_b[4],
                      1'b0, lvl_b[6], 1'b0, lvl_b[4]};
      end
      IOPCD_SEL_B_LOW: begin
        next_rdata = {shown_b[3:0], lvl_b[3:0]};
      end
      IOPCD_SEL_B_IN: begin
        next_rdata = lvl_b & `IOPCD_B_IMPL;
      end
      IOPCD_SEL_A_EN: begin
        next_rdata = en_a;
      end
      IOPCD_SEL_B_EN: begin
        next_rdata = en_b;
      end
      IOPCD_SEL_STAT: begin
        next_rdata = irq_status;
      end
      IOPCD_SEL_MASK: begin
        next_rdata = irq_mask;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************
  // Interrupt
  // ****************************************
  always_comb begin
    irq_evt = 8'h00;
    irq_evt[`IOPCD_IRQ_A_BIT] = |(cos_a.evt & ~port_a_dir_out);
    irq_evt[`IOPCD_IRQ_B_BIT] = |(cos_b.evt & ~port_b_dir_out);
  end

  assign wr_stat = reg_wr && sel == IOPCD_SEL_STAT;
  assign wr_mask = reg_wr && sel == IOPCD_SEL_MASK;

  iopcd_irq #(.W(8)) u_irq (
    .clk_sys(clk_sys),
    .srst(srst),
    .evt(irq_evt),
    .wr_stat(wr_stat),
    .wr_mask(wr_mask),
    .wdata(reg_wdata),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // ****************************************
  // Checks
  // ****************************************
  a_input_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_rd && reg_addr == `IOPCD_A_IN_OFS) |=> (reg_rdata == $past(lvl_a)))
    else $error("port A input read wrong");

  b_input_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_rd && reg_addr == `IOPCD_B_IN_OFS)
      |=> (reg_rdata == ($past(lvl_b) & `IOPCD_B_IMPL)))
    else $error("port B input read wrong");

  b_low_layout_a: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_rd && reg_addr == `IOPCD_B_LOW_OFS)
      |=> (reg_rdata[5] == 1'b0 && reg_rdata[1] == 1'b0
           && reg_rdata[3] == $past(port_b_pin3, 2)
           && reg_rdata[0] == $past(port_b_pin0, 2)))
    else $error("port B lower register layout wrong");

  a_up_level_a: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_rd && reg_addr == `IOPCD_A_UP_OFS)
      |=> ({4'h0, reg_rdata[3:0]} == ($past(lvl_a) >> 4)))
    else $error("port A upper levels wrong");

  b_up_layout_a: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_rd && reg_addr == `IOPCD_B_UP_OFS)
      |=> ((reg_rdata & 8'hAA) == 8'h00 && reg_rdata[2] == $past(port_b_pin6, 2)))
    else $error("port B upper register layout wrong");

  hidden_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_rd && reg_addr == `IOPCD_A_UP_OFS)
      |=> ((reg_rdata[7:4] & ~$past(en_a[7:4])) == 4'h0
           && (reg_rdata[7:4] & $past(port_a_dir_out[7:4])) == 4'h0))
    else $error("change field shown while hidden");

  en_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_wr && reg_addr == `IOPCD_A_EN_OFS) |=> (en_a == $past(reg_wdata)))
    else $error("port A enable not written");

  en_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
    1'b1 |=> ((cos_a.flag & ~$past(en_a)) == 8'h00))
    else $error("flag set on a disabled detector");

  out_detect_a: assert property (@(posedge clk_sys) disable iff (srst)
    (port_a_dir_out[0] && cos_a.evt[0]) |=> cos_a.flag[0])
    else $error("output pin change not recorded");

  flag_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    (cos_a.flag[4] && en_a[4] && !(reg_rd && reg_addr == `IOPCD_A_UP_OFS))
      |=> cos_a.flag[4])
    else $error("change flag dropped without a read");

  read_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_rd && reg_addr == `IOPCD_A_UP_OFS && cos_a.evt[7:4] == 4'h0)
      |=> (cos_a.flag[7:4] == 4'h0))
    else $error("read did not clear port A upper flags");

  flag_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_rd && reg_addr == `IOPCD_A_LOW_OFS && shown_a[1]) |=> reg_rdata[5])
    else $error("set change flag read as zero");

  idle_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data outside the read answer cycle");

  a_low_level_a: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_rd && reg_addr == `IOPCD_A_LOW_OFS)
      |=> (reg_rdata[3:0] == $past(port_a_pin[3:0], 2)))
    else $error("port A lower levels differ from the pins");

  b_hidden_a: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_rd && reg_addr == `IOPCD_B_LOW_OFS)
      |=> ((reg_rdata[7:4] & ~$past(en_b[3:0])) == 4'h0
           && (reg_rdata[7:4] & $past(port_b_dir_out[3:0])) == 4'h0))
    else $error("port B change field shown while hidden");

  chg_cause_a: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(cos_a.flag[0])
      |-> ($past(en_a[0]) && $past(port_a_pin[0], 2) != $past(port_a_pin[0], 3)))
    else $error("flag rose without an enabled pin change");

  out_pin_seen_a: assert property (@(posedge clk_sys) disable iff (srst)
    (en_a[4] && !$past(srst) && !$past(srst, 2)
      && $past(port_a_pin[4]) != $past(port_a_pin[4], 2))
      |=> cos_a.flag[4])
    else $error("enabled detector missed a pin change");

  b_read_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_rd && reg_addr == `IOPCD_B_LOW_OFS && cos_b.evt[3:0] == 4'h0)
      |=> (cos_b.flag[3:0] == 4'h0))
    else $error("read did not clear port B lower flags");

  b_en_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_wr && reg_addr == `IOPCD_B_EN_OFS)
      |=> (en_b == ($past(reg_wdata) & `IOPCD_B_IMPL)))
    else $error("port B enable not written");
endmodule

// ### shared/iopcd_cfg.svh
// Offsets, field layouts, reset values and masks for the I/O port change block
`ifndef IOPCD_CFG_SVH
`define IOPCD_CFG_SVH

// ****************************************
// Widths
// ****************************************
`define IOPCD_AW 8
`define IOPCD_DW 8

// ****************************************
// Register offsets
// ****************************************
`define IOPCD_A_UP_OFS 8'h13
`define IOPCD_A_LOW_OFS 8'h14
`define IOPCD_A_IN_OFS 8'h15
`define IOPCD_B_UP_OFS 8'h1B
`define IOPCD_B_LOW_OFS 8'h1C
`define IOPCD_B_IN_OFS 8'h1D
`define IOPCD_A_EN_OFS 8'h32
`define IOPCD_B_EN_OFS 8'h33
`define IOPCD_IRQ_STAT_OFS 8'h40
`define IOPCD_IRQ_MASK_OFS 8'h41

// ****************************************
// Fields, masks and reset values
// ****************************************
`define IOPCD_B_IMPL 8'h5D
`define IOPCD_LOW_NIB 8'h0F
`define IOPCD_HIGH_NIB 8'hF0
`define IOPCD_EN_RST 8'h00
`define IOPCD_MASK_RST 8'h00
`define IOPCD_IRQ_A_BIT 0
`define IOPCD_IRQ_B_BIT 1

`endif

// ### shared/iopcd_pkg.sv
// Types shared by the I/O port change block
package iopcd_pkg;
  typedef logic [7:0] iopcd_byte_t;
  typedef enum {
    IOPCD_SEL_NONE,
    IOPCD_SEL_A_UP,
    IOPCD_SEL_A_LOW,
    IOPCD_SEL_A_IN,
    IOPCD_SEL_B_UP,
    IOPCD_SEL_B_LOW,
    IOPCD_SEL_B_IN,
    IOPCD_SEL_A_EN,
    IOPCD_SEL_B_EN,
    IOPCD_SEL_STAT,
    IOPCD_SEL_MASK
  } iopcd_sel_e;
endpackage

// ### shared/iopcd_cos_if.sv
// Carrier between the top and one change-of-state detector bank
`timescale 1ns/10ps
interface iopcd_cos_if #(parameter int W = 8);
  logic [W-1:0] lvl;
  logic [W-1:0] en;
  logic [W-1:0] clr;
  logic [W-1:0] flag;
  logic [W-1:0] evt;
  modport det (input lvl, input en, input clr, output flag, output evt);
  modport ctl (output lvl, output en, output clr, input flag, input evt);
endinterface

// ### src/iopcd_cos_det.sv
// Bank of change-of-state detectors with sticky flags
`timescale 1ns/10ps
module iopcd_cos_det #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Detector signals
  iopcd_cos_if.det cos
);
  logic [W-1:0] prev;
  logic [W-1:0] flag;
  logic [W-1:0] chg;
  logic seen;
  logic armed;

  // ****************************************
  // Previous sample and arming
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prev <= '0;
      seen <= 1'b0;
      armed <= 1'b0;
    end else begin
      prev <= cos.lvl;
      seen <= 1'b1;
      armed <= seen;
    end
  end

  // Runs whatever the pin direction
  assign chg = {W{armed}} & (cos.lvl ^ prev) & cos.en;

  // ****************************************
  // Sticky flags, set wins over clear
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flag <= '0;
    end else begin
      flag <= (flag & ~cos.clr & cos.en) | chg;
    end
  end

  assign cos.flag = flag;
  assign cos.evt = chg;

  flag_set_a: assert property (@(posedge clk_sys) disable iff (srst)
    (chg != '0) |=> ((flag & $past(chg)) == $past(chg)))
    else $error("change did not set its flag");
endmodule

// ### src/iopcd_irq.sv
// Sticky interrupt status with mask and level output
`timescale 1ns/10ps
`include "iopcd_cfg.svh"
module iopcd_irq #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Events and register writes
  input wire logic [W-1:0] evt,
  input wire logic wr_stat,
  input wire logic wr_mask,
  input wire logic [W-1:0] wdata,
  // State
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status <= '0;
    end else if (wr_stat) begin
      status <= (status & ~wdata) | evt;
    end else begin
      status <= status | evt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mask <= W'(`IOPCD_MASK_RST);
    end else if (wr_mask) begin
      mask <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  irq_level_a: assert property (@(posedge clk_sys) disable iff (srst)
    1'b1 |=> (irq == |($past(status) & $past(mask))))
    else $error("interrupt level disagrees with status and mask");
endmodule

// ### test/iopcd_pins.sv
// Pin-side model: drives port A and B pin levels on request
`timescale 1ns/10ps
module iopcd_pins (
  // Clock
  input wire logic clk_sys,
  // Requested levels
  input wire logic [7:0] want_a,
  input wire logic [7:0] want_b,
  // Pins
  output logic [7:0] port_a_pin,
  output logic [7:0] port_b_pin
);
  // Pins move just after an edge, like a synchronous source
  always_ff @(posedge clk_sys) begin
    port_a_pin <= want_a;
    port_b_pin <= want_b & 8'h5D;
  end
endmodule

// ### test/iopcd_top_tb_top.sv
// Self-checking bench for the I/O port change block
`timescale 1ns/10ps
`include "iopcd_cfg.svh"
module iopcd_top_tb_top
  import iopcd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst;
  iopcd_byte_t reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, irq;
  logic [7:0] want_a, want_b, pin_a, pin_b, dir_a, dir_b;
  int failures = 0;
  int n_compared = 0;

  always #5 clk_sys = ~clk_sys;

  iopcd_pins pins (.clk_sys(clk_sys), .want_a(want_a), .want_b(want_b),
    .port_a_pin(pin_a), .port_b_pin(pin_b));

  iopcd_top dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_a_pin(pin_a), .port_b_pin0(pin_b[0]), .port_b_pin2(pin_b[2]),
    .port_b_pin3(pin_b[3]), .port_b_pin4(pin_b[4]), .port_b_pin6(pin_b[6]),
    .port_a_dir_out(dir_a), .port_b_dir_out(dir_b), .irq(irq));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic close_out;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input iopcd_byte_t got, input iopcd_byte_t exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input iopcd_byte_t a, input iopcd_byte_t d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input string what, input iopcd_byte_t a, input iopcd_byte_t exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask

  task automatic pins_to(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_sys);
    want_a <= a;
    want_b <= b;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask

  task automatic irq_after(input int n, input logic exp);
    repeat (n) @(posedge clk_sys);
    #1;
    chk("irq", {7'h00, irq}, {7'h00, exp});
  endtask

  function automatic iopcd_byte_t bup(input iopcd_byte_t f, input iopcd_byte_t l);
    return {1'b0, f[6], 1'b0, f[4], 1'b0, l[6], 1'b0, l[4]};
  endfunction

  function automatic iopcd_byte_t blo(input iopcd_byte_t f, input iopcd_byte_t l);
    return {f[3], f[2], 1'b0, f[0], l[3], l[2], 1'b0, l[0]};
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_levels;
    logic [7:0] pat [3] = '{8'hA5, 8'h5A, 8'hFF};
    logic [7:0] lb;
    foreach (pat[i]) begin
      lb = ~pat[i] & 8'h5D;
      pins_to(pat[i], ~pat[i]);
      rchk("a_in", 8'h15, pat[i]);
      rchk("b_in", 8'h1D, lb);
      rchk("a_up", 8'h13, {4'h0, pat[i][7:4]});
      rchk("b_up", 8'h1B, bup(8'h00, lb));
      rchk("b_lo", 8'h1C, blo(8'h00, lb));
    end
  endtask

  task automatic t_regs;
    rchk("a_en_rst", 8'h32, 8'h00);
    rchk("b_en_rst", 8'h33, 8'h00);
    rchk("mask_rst", 8'h41, 8'h00);
    rchk("unmapped", 8'h00, 8'h00);
    wr(8'h15, 8'h00);
    rchk("a_in_ro", 8'h15, 8'hFF);
    wr(8'h33, 8'hFF);
    rchk("b_en", 8'h33, 8'h5D);
    wr(8'h32, 8'h0F);
    rchk("a_en", 8'h32, 8'h0F);
  endtask

  task automatic t_detect;
    pins_to(8'h00, 8'h5D);
    rchk("a_up_off", 8'h13, 8'h00);
    rchk("a_lo_on", 8'h14, 8'hF0);
    rchk("b_up_chg", 8'h1B, bup(8'h5D, 8'h5D));
    rchk("b_lo_chg", 8'h1C, blo(8'h5D, 8'h5D));
    rchk("a_lo_clr", 8'h14, 8'h00);
    rchk("b_lo_clr", 8'h1C, blo(8'h00, 8'h5D));
  endtask

  task automatic t_hide;
    wr(8'h32, 8'hFF);
    @(posedge clk_sys);
    dir_a <= 8'hF0;
    dir_b <= 8'hFF;
    pins_to(8'hFF, 8'h00);
    rchk("a_lo_in", 8'h14, 8'hFF);
    rchk("b_lo_out", 8'h1C, 8'h00);
    @(posedge clk_sys);
    dir_a <= 8'h00;
    dir_b <= 8'h00;
    rchk("a_up_kept", 8'h13, 8'hFF);
    rchk("b_up_kept", 8'h1B, bup(8'h50, 8'h00));
    @(posedge clk_sys);
    dir_a <= 8'hF0;
    pins_to(8'h0F, 8'h00);
    rchk("a_up_out", 8'h13, 8'h00);
  endtask

  task automatic t_irq;
    @(posedge clk_sys);
    dir_a <= 8'h00;
    wr(8'h40, 8'h03);
    wr(8'h41, 8'h01);
    irq_after(2, 1'b0);
    pins_to(8'h0E, 8'h00);
    irq_after(0, 1'b1);
    rchk("stat_a", 8'h40, 8'h01);
    wr(8'h40, 8'h01);
    irq_after(2, 1'b0);
    pins_to(8'h0E, 8'h01);
    rchk("stat_b", 8'h40, 8'h02);
    irq_after(0, 1'b0);
    wr(8'h41, 8'h03);
    irq_after(2, 1'b1);
    rchk("mask", 8'h41, 8'h03);
    wr(8'h40, 8'h02);
    irq_after(2, 1'b0);
  endtask

  task automatic t_reset;
    pins_to(8'h55, 8'h00);
    irq_after(0, 1'b1);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("irq_rst2", {7'h00, irq}, 8'h00);
    rchk("a_en_rst2", 8'h32, 8'h00);
    rchk("stat_rst2", 8'h40, 8'h00);
    rchk("a_lo_rst2", 8'h14, 8'h05);
    rchk("b_lo_rst2", 8'h1C, 8'h00);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    want_a = 8'h00;
    want_b = 8'h00;
    dir_a = 8'h00;
    dir_b = 8'h00;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq_rst", {7'h00, irq}, 8'h00);
    t_levels();
    t_regs();
    t_detect();
    t_hide();
    t_irq();
    t_reset();
    close_out();
  end

  initial begin
    #200000;
    failures++;
    close_out();
  end
endmodule
